//--- verilog/sas_pkg.sv
// Purpose: shared constants and types of the converter sequencer
// Assumes: 32-bit AHB-Lite register words
// Notes: offsets are byte addresses
package sas_pkg;
   localparam logic [7:0] SAS_CTRL_OFS = 8'h00;
   localparam logic [7:0] SAS_CFG_OFS = 8'h04;
   localparam logic [7:0] SAS_ACC_OFS = 8'h08;
   localparam logic [7:0] SAS_RES_OFS = 8'h0c;
   // control word bit positions
   localparam int SAS_BUSY_BIT = 0;
   localparam int SAS_DONE_BIT = 1;
   localparam int SAS_TM_BIT = 2;
   localparam int SAS_BURST_BIT = 3;
   localparam int SAS_IE_BIT = 4;
   localparam int SAS_STBY_BIT = 5;
   localparam int SAS_SRC_LSB = 8;
   // config word bit positions
   localparam int SAS_DIV_LSB = 0;
   localparam int SAS_T2W_BIT = 8;
   localparam int SAS_T3W_BIT = 9;
   // accumulator config bit positions
   localparam int SAS_RPT_LSB = 0;
   localparam int SAS_JST_LSB = 4;
   // timing in conversion clocks
   localparam int SAS_TRACK_CLKS = 3;
   localparam int SAS_CONV_CLKS = 11;
   localparam logic [2:0] SAS_JST_LEFT = 3'h4;
   localparam logic [2:0] SAS_SRC_SW = 3'h0;
   localparam logic [2:0] SAS_SRC_T0 = 3'h1;
   localparam logic [2:0] SAS_SRC_T2 = 3'h2;
   localparam logic [2:0] SAS_SRC_T3 = 3'h3;
   localparam logic [2:0] SAS_SRC_EXT = 3'h4;

   typedef struct packed {
      logic [2:0] start_source_sel;
      logic track_mode_bit;
      logic burst_enable_bit;
      logic int_en;
      logic standby;
      logic [4:0] conv_clock_divider;
      logic t2_wide;
      logic t3_wide;
      logic [2:0] repeat_count_sel;
      logic [2:0] justify_shift_sel;
   } sas_cfg_type;

   localparam sas_cfg_type SAS_CFG_RESET = '0;

   typedef enum logic [1:0] {
      SAS_IDLE = 2'b00,
      SAS_TRACK = 2'b01,
      SAS_CONV = 2'b10
   } sas_state_type;

   // samples per series, minus one
   function automatic logic [5:0] sas_rpt_last(input logic [2:0] sel);
      case (sel)
         3'h0: sas_rpt_last = 6'h00;
         3'h1: sas_rpt_last = 6'h03;
         3'h2: sas_rpt_last = 6'h07;
         3'h3: sas_rpt_last = 6'h0f;
         3'h4: sas_rpt_last = 6'h1f;
         default: sas_rpt_last = 6'h3f;
      endcase
   endfunction
endpackage

//--- verilog/sas_clk_div.sv
// Purpose: conversion clock enable from system clock or low-power oscillator
// Assumes: lpo_tick is one cycle per rising oscillator edge, already synchronised
// Notes: divide value n gives one tick per n+1 source ticks
`timescale 1ns/1ps
`default_nettype none
module sas_clk_div #(
   parameter int DIV_W = 5
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic burst,
   input wire logic lpo_tick,
   input wire logic [DIV_W-1:0] div,
   output logic tick
);
   logic [DIV_W-1:0] cnt;
   wire src_tick = burst ? lpo_tick : 1'b1;
   wire wrap = src_tick && (cnt >= div);

   initial begin
      if (DIV_W < 1 || DIV_W > 8) $error("sas_clk_div: DIV_W out of range");
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt <= '0;
      end else if (wrap) begin
         cnt <= '0;
      end else if (src_tick) begin
         cnt <= cnt + 1'b1;
      end
   end

   assign tick = wrap;
endmodule // sas_clk_div
`default_nettype wire

//--- verilog/sas_format.sv
// Purpose: places the accumulated sum into the 16-bit result word
// Assumes: single samples are 10-bit codes in the low bits of acc
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module sas_format (
   input wire logic [15:0] acc,
   input wire logic [2:0] justify_shift_sel,
   output logic [15:0] result
);
   import sas_pkg::*;
   // left alignment only meaningful for one sample
   wire [15:0] left_val = {acc[9:0], 6'h00};
   wire [15:0] right_val = acc >> justify_shift_sel[1:0];
   assign result = (justify_shift_sel == SAS_JST_LEFT) ? left_val : right_val;
endmodule // sas_format
`default_nettype wire

//--- verilog/sas_top.sv
// Purpose: start, track and convert sequencing with sample accumulator
// Assumes: sar_code is valid when a conversion ends; timer strobes on clk_sys
// Notes: registers over AHB-Lite, zero wait states
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sas_top (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic timer0_ovf,
   input wire logic timer2_low_ovf,
   input wire logic timer2_high_ovf,
   input wire logic timer3_low_ovf,
   input wire logic timer3_high_ovf,
   input wire logic external_start_input,
   input wire logic lp_osc,
   input wire logic [9:0] sar_code,
   output logic track_en,
   output logic conv_active,
   output logic conv_irq,
   output logic [7:0] result_high_byte,
   output logic [7:0] result_low_byte
);
   import sas_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic ext_s1, ext_s2, ext_s3;
   logic lpo_s1, lpo_s2, lpo_s3;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         {ext_s1, ext_s2, ext_s3} <= 3'h0;
         {lpo_s1, lpo_s2, lpo_s3} <= 3'h0;
      end else begin
         {ext_s1, ext_s2, ext_s3} <= {external_start_input, ext_s1, ext_s2};
         {lpo_s1, lpo_s2, lpo_s3} <= {lp_osc, lpo_s1, lpo_s2};
      end
   end
   wire ext_rise = ext_s2 && !ext_s3;
   wire lpo_tick = lpo_s2 && !lpo_s3;

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave
   sas_cfg_type cfg;
   logic busy, done;
   logic [15:0] result;
   logic wr_pend;
   logic [7:0] wr_ofs;
   wire addr_ok = hsel && htrans[1] && hready;
   wire [7:0] a_ofs = haddr[7:0];
   wire wr_ctrl = wr_pend && (wr_ofs == SAS_CTRL_OFS);
   wire wr_cfg = wr_pend && (wr_ofs == SAS_CFG_OFS);
   wire wr_acc = wr_pend && (wr_ofs == SAS_ACC_OFS);
   wire [31:0] ctrl_word = {21'h0, cfg.start_source_sel, 2'h0, cfg.standby,
      cfg.int_en, cfg.burst_enable_bit, cfg.track_mode_bit, done, busy};
   wire [31:0] cfg_word = {22'h0, cfg.t3_wide, cfg.t2_wide, 3'h0,
      cfg.conv_clock_divider};
   wire [31:0] acc_word = {25'h0, cfg.justify_shift_sel, 1'b0, cfg.repeat_count_sel};
   wire [31:0] rd_mux = (a_ofs == SAS_CTRL_OFS) ? ctrl_word :
                        (a_ofs == SAS_CFG_OFS) ? cfg_word :
                        (a_ofs == SAS_ACC_OFS) ? acc_word :
                        (a_ofs == SAS_RES_OFS) ? {16'h0, result} : 32'h0;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wr_pend <= 1'b0;
         wr_ofs <= 8'h00;
         hrdata <= 32'h0;
      end else begin
         wr_pend <= addr_ok && hwrite;
         wr_ofs <= a_ofs;
         if (addr_ok && !hwrite) begin
            hrdata <= rd_mux;
         end
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cfg <= SAS_CFG_RESET;
      end else begin
         if (wr_ctrl) begin
            cfg.start_source_sel <= hwdata[SAS_SRC_LSB +: 3];
            cfg.standby <= hwdata[SAS_STBY_BIT];
            cfg.int_en <= hwdata[SAS_IE_BIT];
            cfg.burst_enable_bit <= hwdata[SAS_BURST_BIT];
            cfg.track_mode_bit <= hwdata[SAS_TM_BIT];
         end
         if (wr_cfg) begin
            cfg.conv_clock_divider <= hwdata[SAS_DIV_LSB +: 5];
            cfg.t2_wide <= hwdata[SAS_T2W_BIT];
            cfg.t3_wide <= hwdata[SAS_T3W_BIT];
         end
         if (wr_acc) begin
            cfg.repeat_count_sel <= hwdata[SAS_RPT_LSB +: 3];
            cfg.justify_shift_sel <= hwdata[SAS_JST_LSB +: 3];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // start source selection
   wire sw_start = wr_ctrl && hwdata[SAS_BUSY_BIT];
   wire t2_ovf = cfg.t2_wide ? timer2_high_ovf : timer2_low_ovf;
   wire t3_ovf = cfg.t3_wide ? timer3_high_ovf : timer3_low_ovf;
   logic start_evt;
   always_comb begin
      unique case (cfg.start_source_sel)
         SAS_SRC_SW: start_evt = sw_start;
         SAS_SRC_T0: start_evt = timer0_ovf;
         SAS_SRC_T2: start_evt = t2_ovf;
         SAS_SRC_T3: start_evt = t3_ovf;
         SAS_SRC_EXT: start_evt = ext_rise;
         default: start_evt = 1'b0;
      endcase
   end
   // external start in low-power mode already tracked while the pin was low
   wire skip_track = (cfg.start_source_sel == SAS_SRC_EXT);
   // a start written together with the mode bit obeys the new bit
   wire tm_now = wr_ctrl ? hwdata[SAS_TM_BIT] : cfg.track_mode_bit;

   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   logic conv_tick;
   sas_clk_div #(.DIV_W(5)) u_div (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .burst(cfg.burst_enable_bit),
      .lpo_tick(lpo_tick),
      .div(cfg.conv_clock_divider),
      .tick(conv_tick)
   );

   sas_state_type state, next_state;
   logic [3:0] phase;
   logic [5:0] cnt;
   logic [15:0] acc;
   wire [5:0] rpt_last = sas_rpt_last(cfg.repeat_count_sel);
   wire conv_end = (state == SAS_CONV) && conv_tick &&
                   (phase == 4'(SAS_CONV_CLKS - 1));
   wire series_end = conv_end && (cnt == rpt_last);
   wire more_burst = conv_end && !series_end && cfg.burst_enable_bit;
   wire [15:0] acc_sum = acc + {6'h00, sar_code};
   wire track_done = (state == SAS_TRACK) && conv_tick &&
                     (phase == 4'(SAS_TRACK_CLKS - 1));
   wire [15:0] fmt_result;

   always_comb begin
      next_state = state;
      unique case (state)
         SAS_IDLE: begin
            if (start_evt) begin
               next_state = (tm_now && !skip_track) ? SAS_TRACK : SAS_CONV;
            end
         end
         SAS_TRACK: begin
            if (track_done) begin
               next_state = SAS_CONV;
            end
         end
         SAS_CONV: begin
            if (more_burst) begin
               next_state = cfg.track_mode_bit ? SAS_TRACK : SAS_CONV;
            end else if (conv_end) begin
               next_state = SAS_IDLE;
            end
         end
         default: next_state = SAS_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state <= SAS_IDLE;
         phase <= 4'h0;
      end else begin
         state <= next_state;
         if (next_state != state || (conv_tick && conv_end)) begin
            phase <= 4'h0;
         end else if (conv_tick && state != SAS_IDLE) begin
            phase <= phase + 4'h1;
         end
      end
   end

   // sample counter and accumulator
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt <= 6'h00;
         acc <= 16'h0;
      end else if (series_end) begin
         cnt <= 6'h00;
         acc <= 16'h0;
      end else if (conv_end) begin
         cnt <= cnt + 6'h01;
         acc <= acc_sum;
      end
   end

   sas_format u_fmt (
      .acc(acc_sum),
      .justify_shift_sel(cfg.justify_shift_sel),
      .result(fmt_result)
   );

   // result word, busy and done
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         result <= 16'h0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         if (series_end) begin
            result <= fmt_result;
         end
         busy <= (next_state != SAS_IDLE);
         if (series_end) begin
            done <= 1'b1;
         end else if (wr_ctrl && !hwdata[SAS_DONE_BIT]) begin
            done <= 1'b0;
         end
      end
   end

   assign result_high_byte = result[15:8];
   assign result_low_byte = result[7:0];
   assign conv_active = busy;
   assign conv_irq = done && cfg.int_en;
   // tracking gate; standby overrides every mode
   wire idle_track = (state == SAS_IDLE) && !cfg.burst_enable_bit &&
                     (cfg.track_mode_bit ? (skip_track && !ext_s2) : 1'b1);
   assign track_en = !cfg.standby && (idle_track || state == SAS_TRACK);

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_done_on_busy_fall;
      @(posedge clk_sys) disable iff (!rstn)
      $rose(done) |-> $fell(busy) && !busy;
   endproperty
   a_done_on_busy_fall: assert property (p_done_on_busy_fall)
      else $error("done rose without busy falling");

   property p_busy_in_conv;
      @(posedge clk_sys) disable iff (!rstn)
      (state == SAS_CONV) |-> busy;
   endproperty
   a_busy_in_conv: assert property (p_busy_in_conv)
      else $error("busy low during conversion");

   property p_result_at_end;
      @(posedge clk_sys) disable iff (!rstn)
      $changed(result) |-> $past(series_end);
   endproperty
   a_result_at_end: assert property (p_result_at_end)
      else $error("result changed mid series");

   property p_acc_clear;
      @(posedge clk_sys) disable iff (!rstn)
      series_end |=> acc == 16'h0 && cnt == 6'h00;
   endproperty
   a_acc_clear: assert property (p_acc_clear)
      else $error("accumulator not cleared for new series");

   property p_track_three;
      @(posedge clk_sys) disable iff (!rstn)
      ($past(state) == SAS_TRACK && state == SAS_CONV) |->
         $past(phase) == 4'(SAS_TRACK_CLKS - 1) && $past(conv_tick);
   endproperty
   a_track_three: assert property (p_track_three)
      else $error("tracking interval not three conversion clocks");

   property p_single_zero;
      @(posedge clk_sys) disable iff (!rstn)
      (series_end && cfg.repeat_count_sel == 3'h0 && cfg.justify_shift_sel == 3'h0)
         |=> result[15:10] == 6'h00 && result[9:0] == $past(sar_code);
   endproperty
   a_single_zero: assert property (p_single_zero)
      else $error("single sample result malformed");

   property p_ext_track_low;
      @(posedge clk_sys) disable iff (!rstn)
      (track_en && state == SAS_IDLE && cfg.track_mode_bit) |-> !ext_s2;
   endproperty
   a_ext_track_low: assert property (p_ext_track_low)
      else $error("tracking while external start high");

   property p_done_full_series;
      @(posedge clk_sys) disable iff (!rstn)
      (conv_end && cnt != rpt_last && !done) |=> !done;
   endproperty
   a_done_full_series: assert property (p_done_full_series)
      else $error("done set before series complete");
endmodule // sas_top
`default_nettype wire

//--- testbench/sas_far_model.sv
// Purpose: converter analog side and low-power oscillator for the sequencer bench
// Assumes: the bench sets the code that the next conversion returns
// Notes: code is inverted outside conversions so a stale sample shows up
`timescale 1ns/1ps
`default_nettype none
module sas_far_model (
   input wire logic conv_active,
   input wire logic [9:0] code,
   output logic [9:0] sar_code,
   output logic lp_osc
);
   // free-running oscillator, phase unrelated to clk_sys
   initial begin
      lp_osc = 1'b0;
      forever #37 lp_osc = ~lp_osc;
   end
   // held code is only trustworthy while converting
   assign sar_code = conv_active ? code : ~code;
endmodule // sas_far_model
`default_nettype wire

//--- testbench/tb.sv
// Purpose: self-checking bench of the converter sequencer
// Assumes: zero wait state AHB-Lite slave, done polled through conv_irq
// Notes: expected results queued by the driver, checked by a monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sas_pkg::*;
   logic clk_sys, rstn, hsel, hwrite, ext, irq_d, hresp, hreadyout, track_en, conv_active, conv_irq;
   logic [31:0] haddr, hwdata, hrdata, rd, lf;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [4:0] tmr;
   logic [9:0] code, sar_code;
   logic [7:0] result_high_byte, result_low_byte;
   logic [15:0] exp_q[$];
   logic [15:0] prev, sum;
   logic lp_osc, g_tm, g_burst;
   int n_fail, comparisons, len0, len1, len2, cnt;
   int src_t[5] = '{1, 2, 2, 3, 3};
   int cfg_t[5] = '{0, 0, 256, 0, 512};
   int bad_t[5] = '{1, 2, 1, 4, 3};
   int ok_t[5] = '{0, 1, 2, 3, 4};
   sas_top sas_top_i (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer0_ovf(tmr[0]),
      .timer2_low_ovf(tmr[1]), .timer2_high_ovf(tmr[2]), .timer3_low_ovf(tmr[3]),
      .timer3_high_ovf(tmr[4]), .external_start_input(ext), .lp_osc(lp_osc),
      .sar_code(sar_code), .track_en(track_en), .conv_active(conv_active),
      .conv_irq(conv_irq), .result_high_byte(result_high_byte),
      .result_low_byte(result_low_byte));
   sas_far_model sas_far_model_i (.conv_active(conv_active), .code(code),
      .sar_code(sar_code), .lp_osc(lp_osc));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
   endfunction
   function automatic logic [31:0] ctrl(input logic busy, input logic stby, input logic [2:0] s);
      ctrl = {21'h0, s, 2'b00, stby, 1'b1, g_burst, g_tm, 1'b0, busy};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_res(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %0t result %h expected %h", $time, got, exp);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a}; hsize <= 3'h2;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk(hresp, 0);
   endtask
   // waits for one busy period (one conversion, or a whole series in burst) and counts its busy cycles
   task automatic wait_conv(output int n);
      int t;
      t = 0;
      n = 0;
      while (conv_active !== 1'b1 && t < 8) begin
         @(posedge clk_sys);
         t++;
      end
      while (conv_active === 1'b1 && n < 20000) begin
         @(posedge clk_sys);
         n++;
         if (n == 1 && !g_burst) chk(track_en, g_tm);
         if (n == 6 && !g_burst) chk(track_en, 0);
      end
      chk(n < 20000, 1);
   endtask
   task automatic run_sw(output int n);
      ahb(1, SAS_CTRL_OFS, ctrl(1, 0, SAS_SRC_SW));
      wait_conv(n);
   endtask
   task automatic pulse(input int i);
      @(posedge clk_sys);
      tmr <= 5'h1 << i;
      @(posedge clk_sys);
      tmr <= 5'h0;
   endtask
   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   initial begin
      #500000;
      n_fail++;
      finish_test;
   end
   always @(posedge clk_sys) begin
      irq_d <= conv_irq;
      if (conv_irq === 1'b1 && irq_d === 1'b0) begin
         if (exp_q.size() == 0) begin
            n_fail++;
            $display("Error %0t result without request", $time);
         end else chk_res({result_high_byte, result_low_byte}, exp_q.pop_front());
      end
   end
   initial begin
      rstn = 1'b0; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0; hsize = 3'h2;
      hwdata = '0; tmr = '0; ext = 1'b0; code = '0; irq_d = 1'b0; lf = 32'he801;
      g_tm = 1'b0; g_burst = 1'b0; n_fail = 0; comparisons = 0;
      repeat (3) @(posedge clk_sys);
      rstn <= 1'b1;
      chk(track_en, 1);
      ahb(0, SAS_CTRL_OFS, 0);
      chk(rd, 0);
      ahb(1, 8'h10, 32'hffffffff);
      ahb(0, 8'h10, 0);
      chk(rd, 0);
      ahb(1, SAS_CFG_OFS, 0);
      // single samples: right, left justified
      for (int k = 0; k < 3; k++) begin
         ahb(1, SAS_ACC_OFS, (k == 0) ? 32'h0 : 32'h40);
         code <= (k == 2) ? 10'h200 : 10'h3ff;
         exp_q.push_back((k == 0) ? 16'h03ff : (k == 1) ? 16'hffc0 : 16'h8000);
         run_sw(len0);
      end
      ahb(0, SAS_RES_OFS, 0);
      chk(rd, 32'h8000);
      g_tm = 1'b1;
      ahb(1, SAS_ACC_OFS, 0);
      code <= 10'h155;
      exp_q.push_back(16'h0155);
      run_sw(len1);
      chk(len1 - len0, SAS_TRACK_CLKS);
      g_tm = 1'b0;
      ahb(1, SAS_CTRL_OFS, ctrl(0, 1, SAS_SRC_SW));
      @(posedge clk_sys);
      chk(track_en, 0);
      ahb(1, SAS_CFG_OFS, 2);
      exp_q.push_back(16'h0155);
      run_sw(len2);
      chk(len2 >= 3 * len0 - 2 && len2 <= 3 * len0 + 2, 1);
      ahb(1, SAS_CFG_OFS, 0);
      // two series of four, one start per sample, shift right by one then none
      for (int s = 0; s < 2; s++) begin
         ahb(1, SAS_ACC_OFS, (s == 0) ? 32'h11 : 32'h01);
         sum = 16'h0;
         for (int i = 0; i < 4; i++) begin
            lf = lfsr(lf);
            code <= lf[9:0];
            sum = sum + {6'h0, lf[9:0]};
            if (i == 3) exp_q.push_back((s == 0) ? sum >> 1 : sum);
            prev = {result_high_byte, result_low_byte};
            run_sw(cnt);
            if (i < 3) chk(conv_irq, 0);
            if (i < 3) chk({result_high_byte, result_low_byte}, prev);
         end
      end
      // burst: one start per series, repeat count selects 1 to 5
      g_burst = 1'b1;
      code <= 10'h3ff;
      for (int r = 1; r < 6; r++) begin
         ahb(1, SAS_ACC_OFS, (r == 5) ? 32'h35 : (r == 3) ? 32'h23 : r);
         exp_q.push_back((r == 5) ? 16'h1ff8 : (r == 3) ? 16'h0ffc : 16'h3ff << (r + 1));
         ahb(1, SAS_CTRL_OFS, ctrl(1, 0, SAS_SRC_SW));
         wait_conv(cnt);
      end
      g_burst = 1'b0;
      ahb(1, SAS_ACC_OFS, 0);
      // timer sources: the unselected overflow must not start
      for (int k = 0; k < 5; k++) begin
         ahb(1, SAS_CFG_OFS, cfg_t[k]);
         ahb(1, SAS_CTRL_OFS, ctrl(0, 0, src_t[k]));
         pulse(bad_t[k]);
         repeat (4) @(posedge clk_sys);
         chk(conv_active, 0);
         exp_q.push_back(16'h03ff);
         pulse(ok_t[k]);
         wait_conv(cnt);
      end
      // external pin in low-power tracking
      g_tm = 1'b1;
      ahb(1, SAS_CTRL_OFS, ctrl(0, 0, SAS_SRC_EXT));
      repeat (6) @(posedge clk_sys);
      chk(track_en, 1);
      chk(conv_active, 0);
      exp_q.push_back(16'h03ff);
      ext <= 1'b1;
      g_tm = 1'b0;
      wait_conv(cnt);
      ext <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk(exp_q.size(), 0);
      finish_test;
   end
endmodule // tb
`default_nettype wire
